/* File: hdl/serial_rx_segment_pkg.sv */
package serial_rx_segment_pkg;

    // Object index of the input segment as seen by the gateway
    localparam logic [15:0] SEG_OBJECT_INDEX   = 16'h5601;

    localparam int          RX_BUF_DEPTH       = 128;
    localparam int          SEG_BYTES          = 8;
    localparam int          DATA_SLOTS_MAX     = 7;
    localparam logic [2:0]  CAP_WITH_DIAG      = 3'h6;
    localparam logic [2:0]  CAP_WITHOUT_DIAG   = 3'h7;

    // Status byte fields
    localparam int          STAT_LINK_BIT      = 7;
    localparam int          STAT_ECHO_LSB      = 5;
    localparam int          STAT_SEQ_LSB       = 3;
    localparam int          STAT_COUNT_LSB     = 0;

    // Diagnostics byte fields
    localparam int          DIAG_OVERFLOW_BIT  = 7;
    localparam int          DIAG_FRAMING_BIT   = 6;
    localparam int          DIAG_FLOW_BIT      = 5;
    localparam int          DIAG_HARDWARE_BIT  = 4;
    localparam int          DIAG_SETTING_BIT   = 3;

    // Reset values
    localparam logic        LINK_HEALTHY_RESET = 1'b1;
    localparam logic [1:0]  SEQ_RESET          = 2'h0;
    localparam logic [1:0]  ECHO_RESET         = 2'h0;

    // Bytes a terminal may still send after XOFF before it counts as a fault
    localparam int          XOFF_GRACE_BYTES   = 4;

    // Two-entry skid buffer in front of the receive buffer
    localparam int          SKID_DEPTH         = 2;

endpackage

/* File: hdl/rx_byte_buffer.sv */
`timescale 1ns/10ps
`default_nettype none

module rx_byte_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = serial_rx_segment_pkg::SKID_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : badShape
        $error("rx_byte_buffer: WIDTH must be positive and DEPTH a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [PW-1:0]               head;
        logic [PW:0]                 fill;
    } buf_state_t;

    buf_state_t state_reg;
    buf_state_t state_next;
    logic       push;
    logic       pop;

    assign inReady  = (state_reg.fill != (PW+1)'(DEPTH));
    assign outValid = (state_reg.fill != '0);
    assign outData  = state_reg.slot[state_reg.head];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.slot[state_reg.head + state_reg.fill[PW-1:0]] = inData;
        end
        if (pop) begin
            state_next.head = state_reg.head + PW'(1);
        end
        state_next.fill = state_reg.fill + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    fill_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
        state_reg.fill <= (PW+1)'(DEPTH))
        else $error("skid buffer fill above depth");

endmodule

`default_nettype wire

/* File: hdl/serial_rx_segment_framer.sv */
// Function
// - Every received byte enters a 128-byte receive buffer, then leaves in segments.
// - Each input segment is eight bytes; byte 0 is the status byte.
// - A segment carries up to six or seven user data bytes.
// - Diagnostics selected: status byte 0, diagnostics byte 1, data in bytes 2-7.
// - Diagnostics not selected: status byte 0, data bytes 0-6 in bytes 1-7.
// - Status bit 7 is 1 while the link is healthy, 0 after a fault.
// - A fault also raises the separate diagnostics signal unless that signal is off.
// - The link flag returns to 1 only on a falling flag-clear edge.
// - Status bits 6-5 echo the last accepted outbound sequence number.
// - Status bits 4-3 carry the inbound sequence, counting 0,1,2,3,0.
// - Status bits 2-0 give the valid user byte count, 0 to 7.
// - Diagnostics bit 7 shows receive buffer overflow.
// - Diagnostics bit 6 shows a framing fault.
// - Diagnostics bit 5 shows the terminal ignoring XOFF.
// - Diagnostics bit 4 shows an internal hardware fault.
// - A setting-fault flag shows unsupported settings, placed at diagnostics bit 3.
// - With diagnostics selected, byte 1 holds diagnostics whatever the signal-off setting.
`timescale 1ns/10ps
`default_nettype none

module serial_rx_segment_framer #(
    parameter int RX_DEPTH   = serial_rx_segment_pkg::RX_BUF_DEPTH,
    parameter int XOFF_GRACE = serial_rx_segment_pkg::XOFF_GRACE_BYTES
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    output logic             rxReady,
    input  wire logic        framingFaultPulse,
    input  wire logic        xoffActive,
    input  wire logic        hardwareFault,
    input  wire logic        settingFault,
    input  wire logic        diagInDataSelect,
    input  wire logic        diagSignalOff,
    input  wire logic        outSegmentValid,
    input  wire logic        linkFlagClear,
    input  wire logic [1:0]  outboundSeqNumber,
    input  wire logic [1:0]  inboundSeqEcho,
    output logic [63:0]      inputSegment,
    output logic             linkHealthy,
    output logic             diagSignal
);

    localparam int PW = $clog2(RX_DEPTH);

    if (RX_DEPTH < serial_rx_segment_pkg::SEG_BYTES || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
    begin : badDepth
        $error("serial_rx_segment_framer: RX_DEPTH must be a power of two >= 8");
    end
    if (XOFF_GRACE < 1 || XOFF_GRACE > 255) begin : badGrace
        $error("serial_rx_segment_framer: XOFF_GRACE must lie in 1..255");
    end

    typedef struct packed {
        logic [RX_DEPTH-1:0][7:0] mem;
        logic [PW-1:0]            wrPtr;
        logic [PW-1:0]            rdPtr;
        logic [PW:0]              fill;
        logic [6:0][7:0]          segData;
        logic [1:0]               inboundSeq;
        logic [2:0]               validCount;
        logic [1:0]               outboundEcho;
        logic                     linkHealthy;
        logic                     clearPrev;
        logic                     overflow;
        logic                     framing;
        logic                     flowFault;
        logic [7:0]               xoffCount;
        logic                     diagSignal;
        logic [63:0]              segment;
    } framer_state_t;

    framer_state_t state_reg;
    framer_state_t state_next;

    logic       bufValid;
    logic [7:0] bufData;
    logic       bufReady;
    logic       overflowEvent;
    logic       flowEvent;
    logic       faultNow;
    logic       restoreNow;

    // User bytes that fit in one segment under the current layout
    function automatic logic [2:0] segCapacity(input logic diagSel);
        return diagSel ? serial_rx_segment_pkg::CAP_WITH_DIAG
                       : serial_rx_segment_pkg::CAP_WITHOUT_DIAG;
    endfunction

    function automatic logic [7:0] diagByte(input framer_state_t s, input logic hw,
                                            input logic prm);
        logic [7:0] d;
        d = 8'h00;
        d[serial_rx_segment_pkg::DIAG_OVERFLOW_BIT] = s.overflow;
        d[serial_rx_segment_pkg::DIAG_FRAMING_BIT]  = s.framing;
        d[serial_rx_segment_pkg::DIAG_FLOW_BIT]     = s.flowFault;
        d[serial_rx_segment_pkg::DIAG_HARDWARE_BIT] = hw;
        d[serial_rx_segment_pkg::DIAG_SETTING_BIT]  = prm;
        return d;
    endfunction

    function automatic logic [63:0] composeSegment(input framer_state_t s, input logic diagSel,
                                                   input logic hw, input logic prm);
        logic [7:0]  status;
        logic [63:0] seg;
        status = 8'h00;
        status[serial_rx_segment_pkg::STAT_LINK_BIT] = s.linkHealthy;
        status[serial_rx_segment_pkg::STAT_ECHO_LSB +: 2] = s.outboundEcho;
        status[serial_rx_segment_pkg::STAT_SEQ_LSB +: 2] = s.inboundSeq;
        status[serial_rx_segment_pkg::STAT_COUNT_LSB +: 3] = s.validCount;
        seg = 64'h0;
        seg[7:0] = status;
        if (diagSel) begin
            seg[15:8] = diagByte(s, hw, prm);
            for (int i = 0; i < 6; i++) begin
                seg[(i+2)*8 +: 8] = s.segData[i];
            end
        end else begin
            for (int i = 0; i < 7; i++) begin
                seg[(i+1)*8 +: 8] = s.segData[i];
            end
        end
        return seg;
    endfunction

    // Absorbs a stall of the receive buffer so the offered byte is not dropped
    rx_byte_buffer #(
        .WIDTH (8),
        .DEPTH (serial_rx_segment_pkg::SKID_DEPTH)
    ) skid (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .inValid  (rxValid),
        .inData   (rxData),
        .inReady  (rxReady),
        .outValid (bufValid),
        .outData  (bufData),
        .outReady (bufReady)
    );

    assign bufReady      = (state_reg.fill != (PW+1)'(RX_DEPTH));
    assign overflowEvent = rxValid && !rxReady;
    assign flowEvent     = xoffActive && rxValid && rxReady
                           && (state_reg.xoffCount == 8'(XOFF_GRACE));
    assign faultNow      = overflowEvent || framingFaultPulse || flowEvent
                           || hardwareFault || settingFault;
    assign restoreNow    = state_reg.clearPrev && !linkFlagClear;

    always_comb begin
        logic       write;
        logic [2:0] cap;
        logic [2:0] take;
        write = bufValid && bufReady;
        cap   = segCapacity(diagInDataSelect);
        take  = 3'h0;
        state_next = state_reg;

        if (write) begin
            state_next.mem[state_reg.wrPtr] = bufData;
            state_next.wrPtr = state_reg.wrPtr + PW'(1);
        end

        // Load the next segment only after the host has echoed the current one
        if (inboundSeqEcho == state_reg.inboundSeq && state_reg.fill != '0) begin
            take = (state_reg.fill < (PW+1)'(cap)) ? state_reg.fill[2:0] : cap;
            for (int i = 0; i < serial_rx_segment_pkg::DATA_SLOTS_MAX; i++) begin
                state_next.segData[i] = (3'(i) < take)
                                        ? state_reg.mem[state_reg.rdPtr + PW'(i)] : 8'h00;
            end
            state_next.rdPtr      = state_reg.rdPtr + PW'(take);
            state_next.validCount = take;
            state_next.inboundSeq = state_reg.inboundSeq + 2'h1;
        end
        state_next.fill = state_reg.fill + (PW+1)'(write) - (PW+1)'(take);

        if (outSegmentValid) begin
            state_next.outboundEcho = outboundSeqNumber;
        end

        // Bytes the terminal sends while XOFF stands
        if (!xoffActive) begin
            state_next.xoffCount = 8'h00;
        end else if (rxValid && rxReady && state_reg.xoffCount != 8'(XOFF_GRACE)) begin
            state_next.xoffCount = state_reg.xoffCount + 8'h01;
        end

        // Sticky causes; a new event wins over the host's restore
        state_next.overflow  = overflowEvent || (state_reg.overflow && !restoreNow);
        state_next.framing   = framingFaultPulse || (state_reg.framing && !restoreNow);
        state_next.flowFault = flowEvent || (state_reg.flowFault && !restoreNow);

        state_next.clearPrev = linkFlagClear;
        if (faultNow) begin
            state_next.linkHealthy = 1'b0;
        end else if (restoreNow) begin
            state_next.linkHealthy = 1'b1;
        end
        state_next.diagSignal = !state_next.linkHealthy && !diagSignalOff;

        state_next.segment = composeSegment(state_next, diagInDataSelect,
                                            hardwareFault, settingFault);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg             <= '0;
            state_reg.inboundSeq  <= serial_rx_segment_pkg::SEQ_RESET;
            state_reg.outboundEcho <= serial_rx_segment_pkg::ECHO_RESET;
            state_reg.linkHealthy <= serial_rx_segment_pkg::LINK_HEALTHY_RESET;
            state_reg.segment     <= 64'h0000_0000_0000_0080;
        end else begin
            state_reg <= state_next;
        end
    end

    assign inputSegment = state_reg.segment;
    assign linkHealthy  = state_reg.linkHealthy;
    assign diagSignal   = state_reg.diagSignal;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence clearFall;
        linkFlagClear ##1 (!linkFlagClear && !faultNow);
    endsequence

    sequence hostPending;
        inboundSeqEcho != inputSegment[4:3];
    endsequence

    fill_bound_a: assert property (state_reg.fill <= (PW+1)'(RX_DEPTH))
        else $error("receive buffer fill above depth");

    seg_frozen_a: assert property (hostPending ##0 $stable(diagInDataSelect)
        |=> $stable(inputSegment[63:16]) && $stable(inputSegment[4:0]))
        else $error("segment changed before host echo");

    seq_step_a: assert property ($changed(inputSegment[4:3])
        |-> inputSegment[4:3] == $past(inputSegment[4:3]) + 2'h1)
        else $error("inbound sequence skipped a value");

    count_cap_a: assert property (diagInDataSelect && $past(diagInDataSelect)
        && $changed(inputSegment[4:3]) |-> inputSegment[2:0] <= 3'h6)
        else $error("segment count above six with diagnostics byte");

    echo_copy_a: assert property (outSegmentValid
        |=> inputSegment[6:5] == $past(outboundSeqNumber))
        else $error("outbound echo not updated");

    link_drop_a: assert property (hardwareFault
        |=> !linkHealthy && !inputSegment[7])
        else $error("link flag not cleared on fault");

    link_restore_a: assert property (clearFall |=> linkHealthy && inputSegment[7])
        else $error("link flag not restored on falling clear");

    rise_cause_a: assert property ($rose(linkHealthy)
        |-> $past(linkFlagClear, 2) && !$past(linkFlagClear))
        else $error("link flag rose without falling clear");

    diag_signal_a: assert property ($fell(linkHealthy) && !$past(diagSignalOff)
        |-> diagSignal)
        else $error("diagnostics signal missing on fault");

    overflow_show_a: assert property (overflowEvent && diagInDataSelect
        |=> inputSegment[15] && inputSegment[10:8] == 3'h0)
        else $error("overflow not shown in diagnostics byte");

    framing_show_a: assert property (framingFaultPulse && diagInDataSelect
        |=> inputSegment[14] && !linkHealthy)
        else $error("framing fault not shown");

endmodule

`default_nettype wire

/* File: sim/host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module host_model (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [63:0] inputSegment,
    input  wire logic        diagInDataSelect,
    input  wire logic        ackEnable,
    input  wire logic [7:0]  stallCycles,
    output logic [1:0]       inboundSeqEcho
);
    logic [7:0] got[$];
    int         seqBreaks;
    int         maxCount;
    int         cnt;
    int         off;

    // Takes each new segment, then acknowledges it after a programmable delay
    initial begin
        inboundSeqEcho = serial_rx_segment_pkg::SEQ_RESET;
        seqBreaks = 0;
        maxCount = 0;
        forever begin
            @(posedge clk_sys);
            #1;
            if (reset) begin
                inboundSeqEcho = serial_rx_segment_pkg::SEQ_RESET;
            end else if (ackEnable && inputSegment[4:3] !== inboundSeqEcho) begin
                if (inputSegment[4:3] !== inboundSeqEcho + 2'h1) begin
                    seqBreaks++;
                end
                cnt = int'(inputSegment[2:0]);
                off = diagInDataSelect ? 2 : 1;
                maxCount = (cnt > maxCount) ? cnt : maxCount;
                for (int i = 0; i < cnt; i++) begin
                    got.push_back(inputSegment[8*(off+i) +: 8]);
                end
                repeat (stallCycles) begin
                    @(posedge clk_sys);
                    #1;
                end
                inboundSeqEcho = inputSegment[4:3];
            end
        end
    end
endmodule

`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module testbench;
    typedef struct packed {
        logic       sel;
        logic [7:0] n;
        logic [7:0] stall;
        logic [2:0] maxc;
    } row_t;

    localparam int DEPTH = 8;

    logic        clk_sys, reset, rxValid, rxReady, framingFaultPulse, xoffActive;
    logic        hardwareFault, settingFault, diagInDataSelect, diagSignalOff;
    logic        outSegmentValid, linkFlagClear, linkHealthy, diagSignal, ackEnable;
    logic [7:0]  rxData, stallCycles, nextByte;
    logic [1:0]  outboundSeqNumber, inboundSeqEcho;
    logic [63:0] inputSegment, snap;
    logic [7:0]  expQ[$];
    int          fails, checkCount;
    row_t        rows [5] = '{'{1'b0, 8'h01, 8'h00, 3'h1}, '{1'b1, 8'h01, 8'h00, 3'h1},
                              '{1'b0, 8'h0f, 8'h14, 3'h7}, '{1'b1, 8'h0d, 8'h14, 3'h6},
                              '{1'b1, 8'h1e, 8'h19, 3'h6}};

    serial_rx_segment_framer #(.RX_DEPTH(DEPTH), .XOFF_GRACE(1)) serial_rx_segment_framer_inst (
        .clk_sys(clk_sys), .reset(reset), .rxValid(rxValid), .rxData(rxData),
        .rxReady(rxReady), .framingFaultPulse(framingFaultPulse), .xoffActive(xoffActive),
        .hardwareFault(hardwareFault), .settingFault(settingFault),
        .diagInDataSelect(diagInDataSelect), .diagSignalOff(diagSignalOff),
        .outSegmentValid(outSegmentValid), .linkFlagClear(linkFlagClear),
        .outboundSeqNumber(outboundSeqNumber), .inboundSeqEcho(inboundSeqEcho),
        .inputSegment(inputSegment), .linkHealthy(linkHealthy), .diagSignal(diagSignal));

    host_model host_model_inst (
        .clk_sys(clk_sys), .reset(reset), .inputSegment(inputSegment),
        .diagInDataSelect(diagInDataSelect), .ackEnable(ackEnable),
        .stallCycles(stallCycles), .inboundSeqEcho(inboundSeqEcho));

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) step();
    endtask

    // Offers a byte only while ready stands; valid against low ready counts as overflow
    task automatic send_bytes(input int n);
        for (int i = 0; i < n; i++) begin
            while (rxReady !== 1'b1) begin
                rxValid = 1'b0;
                step();
            end
            rxValid = 1'b1;
            rxData  = nextByte;
            step();
            expQ.push_back(nextByte);
            nextByte = nextByte + 8'h01;
        end
        rxValid = 1'b0;
    endtask

    // Waits for every byte and for the host's last echo, so no load is still pending
    task automatic drain_check();
        int k;
        k = 0;
        while (k < 800 && (host_model_inst.got.size() < expQ.size()
                           || inboundSeqEcho !== inputSegment[4:3])) begin
            step();
            k++;
        end
        `CHK("drain time", 1'b1, k < 800)
        `CHK("byte total", expQ.size(), host_model_inst.got.size())
        for (int i = 0; i < expQ.size() && i < host_model_inst.got.size(); i++) begin
            `CHK("data byte", expQ[i], host_model_inst.got[i])
        end
        `CHK("seq breaks", 0, host_model_inst.seqBreaks)
        expQ.delete();
        host_model_inst.got.delete();
    endtask

    task automatic restore();
        linkFlagClear = 1'b1;
        idle(3);
        `CHK("link on rise", 1'b0, linkHealthy)
        linkFlagClear = 1'b0;
        idle(2);
        `CHK("link on fall", 1'b1, linkHealthy)
        `CHK("sticky flags", 3'h0, inputSegment[15:13])
    endtask

    task automatic check_reset();
        `CHK("reset segment", 64'h0000000000000080, inputSegment)
        `CHK("reset link", 1'b1, linkHealthy)
        `CHK("reset diag", 1'b0, diagSignal)
    endtask

    task automatic close_out();
        if (fails == 0 && checkCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        close_out();
    end

    initial begin
        {reset, rxValid, framingFaultPulse, xoffActive, hardwareFault} = 5'h10;
        {settingFault, diagInDataSelect, diagSignalOff, outSegmentValid, linkFlagClear} = 5'h00;
        {rxData, stallCycles, outboundSeqNumber} = 18'h00000;
        {ackEnable, nextByte, fails, checkCount} = {1'b1, 8'h10, 32'h0, 32'h0};
        repeat (8) @(posedge clk_sys);
        #1;
        check_reset();
        reset = 1'b0;
        step();
        check_reset();
        `CHK("ready", 1'b1, rxReady)
        foreach (rows[r]) begin
            diagInDataSelect = rows[r].sel;
            stallCycles = rows[r].stall;
            host_model_inst.maxCount = 0;
            send_bytes(int'(rows[r].n));
            drain_check();
            `CHK("max count", rows[r].maxc, 3'(host_model_inst.maxCount))
        end
        for (int v = 0; v < 4; v++) begin
            outboundSeqNumber = 2'(v);
            outSegmentValid = 1'b1;
            step();
            outSegmentValid = 1'b0;
            outboundSeqNumber = 2'(v + 1);
            idle(2);
            `CHK("outbound echo", 2'(v), inputSegment[6:5])
        end
        diagInDataSelect = 1'b1;
        hardwareFault = 1'b1;
        idle(3);
        `CHK("link", 1'b0, linkHealthy)
        `CHK("status link", 1'b0, inputSegment[7])
        `CHK("hw diag", 8'h10, inputSegment[15:8])
        `CHK("diag signal", 1'b1, diagSignal)
        hardwareFault = 1'b0;
        idle(4);
        `CHK("no self restore", 1'b0, linkHealthy)
        restore();
        diagSignalOff = 1'b1;
        settingFault = 1'b1;
        idle(3);
        `CHK("setting diag", 8'h08, inputSegment[15:8])
        `CHK("signal off", 1'b0, diagSignal)
        settingFault = 1'b0;
        diagSignalOff = 1'b0;
        restore();
        framingFaultPulse = 1'b1;
        step();
        framingFaultPulse = 1'b0;
        idle(2);
        `CHK("framing diag", 8'h40, inputSegment[15:8])
        restore();
        xoffActive = 1'b1;
        send_bytes(1);
        idle(3);
        `CHK("grace byte", 1'b1, linkHealthy)
        send_bytes(1);
        idle(3);
        `CHK("flow diag", 1'b1, inputSegment[13])
        xoffActive = 1'b0;
        drain_check();
        restore();
        // Host stops acknowledging while the sender ignores ready
        ackEnable = 1'b0;
        rxValid = 1'b1;
        idle(DEPTH + 8);
        rxValid = 1'b0;
        idle(3);
        snap = inputSegment;
        `CHK("overflow", 1'b1, inputSegment[15])
        `CHK("overflow link", 1'b0, linkHealthy)
        idle(10);
        `CHK("held", {snap[63:16], snap[4:0]}, {inputSegment[63:16], inputSegment[4:0]})
        reset = 1'b1;
        idle(2);
        reset = 1'b0;
        step();
        check_reset();
        close_out();
    end
endmodule

`default_nettype wire
